// file: inc/psl_pkg.sv
// Constants for the strap loader and link mode configuration block.
// Assumes a 200 MHz core clock and a classic Wishbone register bus.
`default_nettype none
package psl_pkg;
  // Register word indices, byte address is four times the index
  localparam logic [7:0] IDX_CONFIG_ONE = 8'h09;
  localparam logic [7:0] IDX_INT_MASK = 8'h12;
  localparam logic [7:0] IDX_INT_STATUS = 8'h13;
  localparam logic [7:0] IDX_CONFIG_FOUR = 8'h31;
  localparam logic [7:0] IDX_STRAP_CTRL = 8'h40;
  localparam logic [7:0] IDX_LINK_STATUS = 8'h41;
  // config_one fields
  localparam int F_TEST_LO = 13;
  localparam int F_LINK_DROP = 7;
  // config_four fields
  localparam int F_MIRROR = 0;
  localparam int F_SPEED_OPT = 1;
  localparam int F_ENHANCED = 2;
  localparam int F_THRESH_LO = 4;
  // Strap override control fields
  localparam int F_OVR_EN = 15;
  localparam int F_SW_RESET = 14;
  localparam int F_OVR_ADDR_LO = 0;
  localparam int F_OVR_ANEG = 5;
  localparam int F_OVR_MDIX = 6;
  localparam int F_OVR_HD = 7;
  // Interrupt status bits
  localparam int I_LINK = 0;
  localparam int I_DOWNSHIFT = 1;
  localparam int I_TEST = 2;
  // Reset values
  localparam logic [2:0] THRESH_DEFAULT = 3'h4;
  localparam logic [15:0] ZERO16 = 16'h0000;
  // Settle count reached once the synchroniser pipe is full
  localparam logic [1:0] SETTLE_LAST = 2'h3;
  // Strap windows in thousandths of io_supply, lower and upper bounds
  localparam logic [9:0] LVL_M1_MAX = 10'h062;
  localparam logic [9:0] LVL_M2_MIN = 10'h08C;
  localparam logic [9:0] LVL_M2_MAX = 10'h0BF;
  localparam logic [9:0] LVL_M3_MIN = 10'h0E1;
  localparam logic [9:0] LVL_M3_MAX = 10'h11C;
  localparam logic [9:0] LVL_M4_MIN = 10'h2B6;
  localparam logic [9:0] LVL_M4_MAX = 10'h378;
  // Decoded strap codes
  localparam logic [1:0] MODE1 = 2'h0;
  localparam logic [1:0] MODE2 = 2'h1;
  localparam logic [1:0] MODE3 = 2'h2;
  localparam logic [1:0] MODE4 = 2'h3;
  // Link speeds
  typedef enum logic [1:0] {SPD_10, SPD_100, SPD_1000} psl_speed_t;
endpackage
`default_nettype wire

// file: core/psl_top.sv
// Strap loader and link mode configuration: straps, downshift, mirror, test modes.
// Assumes strap levels arrive digitised in thousandths of io_supply, asynchronous.
// Summary of operation
// - Downshift to 100M after failed gigabit attempts
// - Failure threshold programmable, default four
// - Enhanced: one failure without C/D energy
// - Fall to 10M when 100M also fails
// - Speed optimisation from strap or register
// - 10/100 mirror maps A-D, B-C
// - Gigabit mirror maps A-D, B-C, C-B, D-A
// - Mirror from strap or config_four bit
// - Mirror inverts each remapped pair polarity
// - Interrupt sources selected by mask, status
// - Host selects test mode in config_one
// - Test mode drives pattern and clock out
// - Sample straps at power-up and hard reset
// - Software reset reloads latched strap values
// - Four levels decode to two bits
// - Levels classified against supply-relative windows
// - Straps give address, autoneg, crossover, duplex
// - Register writes override strapped values
// - config_one bit 7 forces link drop
//
// Our own choice: register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
module psl_top #(
  parameter int LVL_W = 10
) (
  // Clock, reset, enable
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  // Strap levels, thousandths of io_supply
  input wire logic [LVL_W-1:0] receive_data_line0_lvl_i,
  input wire logic [LVL_W-1:0] receive_data_line2_lvl_i,
  input wire logic [LVL_W-1:0] receive_data_line4_lvl_i,
  input wire logic [LVL_W-1:0] receive_data_line5_lvl_i,
  input wire logic [LVL_W-1:0] speed_opt_lvl_i,
  input wire logic [LVL_W-1:0] mirror_lvl_i,
  // Link side status, same clock
  input wire logic attempt_fail_i,
  input wire logic link_up_i,
  input wire logic energy_cd_i,
  input wire logic mdix_i,
  input wire logic [3:0] tx_pair_p_i,
  input wire logic [3:0] tx_pair_n_i,
  input wire logic test_pattern_i,
  input wire logic test_clk_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Configuration outputs
  output logic [4:0] phy_address_o,
  output logic autoneg_select_bit1_o,
  output logic force_mdix_o,
  output logic half_duplex_enable_o,
  output logic [1:0] speed_o,
  output logic link_drop_o,
  output logic [2:0] test_mode_o,
  output logic [3:0] mdi_p_o,
  output logic [3:0] mdi_n_o,
  output logic clk_out_o,
  output logic int_o
);
  localparam int NS = 6;
  // Synchroniser stages per strap
  logic [LVL_W-1:0] s1 [NS];
  logic [LVL_W-1:0] s2 [NS];
  logic [LVL_W-1:0] s3 [NS];
  logic [LVL_W-1:0] lvl_in [NS];
  // Latched strap codes, captured once per hard reset
  logic [1:0] strap [NS];
  logic strap_done;
  logic [1:0] settle;
  // Registers
  logic [15:0] config_one;
  logic [15:0] interrupt_mask_control;
  logic [15:0] interrupt_status;
  logic [15:0] config_four;
  logic [15:0] strap_ctrl;
  // Downshift state
  logic [2:0] fail_cnt;
  logic gig_failed;
  logic link_q;
  // Bus decode
  logic wb_req;
  logic wb_wr;
  logic [7:0] idx;
  logic sw_reset;
  logic [2:0] ev;
  logic spd_en;
  logic mir_en;
  logic stages_agree; // Stages two and three hold the same level
  assign lvl_in[0] = receive_data_line0_lvl_i;
  assign lvl_in[1] = receive_data_line2_lvl_i;
  assign lvl_in[2] = receive_data_line4_lvl_i;
  assign lvl_in[3] = receive_data_line5_lvl_i;
  assign lvl_in[4] = speed_opt_lvl_i;
  assign lvl_in[5] = mirror_lvl_i;
  // Classify a level against supply windows; gaps fall to nearest lower mode
  function automatic logic [1:0] decode_lvl(input logic [LVL_W-1:0] v);
    if (v >= LVL_W'(psl_pkg::LVL_M4_MIN))
      return psl_pkg::MODE4;
    if (v >= LVL_W'(psl_pkg::LVL_M3_MIN))
      return psl_pkg::MODE3;
    if (v >= LVL_W'(psl_pkg::LVL_M2_MIN))
      return psl_pkg::MODE2;
    return psl_pkg::MODE1;
  endfunction
  // Three-stage synchroniser, first stage read only by the second
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s1 <= '{default: '0};
      s2 <= '{default: '0};
      s3 <= '{default: '0};
    end
    else if (clk_en_i)
    begin
      s1 <= lvl_in;
      s2 <= s1;
      s3 <= s2;
    end
  end
  // A level counts only once the last two stages agree; a slow edge just waits
  always_comb
  begin
    stages_agree = 1'b1;
    for (int i = 0; i < NS; i++)
      if (s2[i] != s3[i])
        stages_agree = 1'b0;
  end
  // Capture straps once after hard reset release, then hold
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      strap_done <= 1'b0;
      settle <= 2'h0;
      strap <= '{default: psl_pkg::MODE1};
    end
    else if (clk_en_i && !strap_done)
    begin
      // Wait for pipeline fill, then require stage agreement
      if (settle != psl_pkg::SETTLE_LAST)
        settle <= settle + 2'h1;
      else if (stages_agree)
      begin
        strap_done <= 1'b1;
        for (int i = 0; i < NS; i++)
          strap[i] <= decode_lvl(s3[i]);
      end
    end
  end
  // Wishbone decode: single-cycle ack, word addressed
  assign idx = wb_adr_i[9:2];
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i;
  assign sw_reset = wb_wr && idx == psl_pkg::IDX_STRAP_CTRL && wb_sel_i[1]
                    && wb_dat_i[psl_pkg::F_SW_RESET];
  // Ack and read data
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else if (clk_en_i)
    begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i)
      begin
        unique case (idx)
          psl_pkg::IDX_CONFIG_ONE: wb_dat_o <= {16'h0000, config_one};
          psl_pkg::IDX_INT_MASK: wb_dat_o <= {16'h0000, interrupt_mask_control};
          psl_pkg::IDX_INT_STATUS: wb_dat_o <= {16'h0000, interrupt_status};
          psl_pkg::IDX_CONFIG_FOUR: wb_dat_o <= {16'h0000, config_four};
          psl_pkg::IDX_STRAP_CTRL: wb_dat_o <= {16'h0000, strap_ctrl};
          psl_pkg::IDX_LINK_STATUS: wb_dat_o <= {24'h000000, fail_cnt, speed_o,
                                                 strap_done, link_q, gig_failed};
          // Unmapped reads return zero
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end
  // Byte-lane write helper for 16-bit registers; upper lanes have no storage
  function automatic logic [15:0] lane_wr(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
    return {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction
  // Writable registers; software reset reloads strap-derived fields
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      config_one <= psl_pkg::ZERO16;
      interrupt_mask_control <= psl_pkg::ZERO16;
      config_four <= {9'h000, psl_pkg::THRESH_DEFAULT, 4'h0};
      strap_ctrl <= psl_pkg::ZERO16;
    end
    else if (clk_en_i)
    begin
      if (sw_reset)
      begin
        // Latched straps reappear; pins are not resampled
        config_one <= psl_pkg::ZERO16;
        config_four <= {9'h000, psl_pkg::THRESH_DEFAULT, 4'h0};
        strap_ctrl <= psl_pkg::ZERO16;
      end
      else if (wb_wr)
      begin
        unique case (idx)
          psl_pkg::IDX_CONFIG_ONE: config_one <= lane_wr(config_one, wb_dat_i, wb_sel_i);
          psl_pkg::IDX_INT_MASK:
            interrupt_mask_control <= lane_wr(interrupt_mask_control, wb_dat_i, wb_sel_i);
          psl_pkg::IDX_CONFIG_FOUR: config_four <= lane_wr(config_four, wb_dat_i, wb_sel_i);
          psl_pkg::IDX_STRAP_CTRL: strap_ctrl <= lane_wr(strap_ctrl, wb_dat_i, wb_sel_i);
          default: ;
        endcase
      end
    end
  end
  // Effective enables: strap or register
  assign spd_en = strap[4][1] || config_four[psl_pkg::F_SPEED_OPT];
  assign mir_en = strap[5][1] || config_four[psl_pkg::F_MIRROR];
  // Strap-derived configuration, replaced when override is set
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      phy_address_o <= '0;
      autoneg_select_bit1_o <= 1'b0;
      force_mdix_o <= 1'b0;
      half_duplex_enable_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (strap_ctrl[psl_pkg::F_OVR_EN])
      begin
        phy_address_o <= strap_ctrl[psl_pkg::F_OVR_ADDR_LO +: 5];
        autoneg_select_bit1_o <= strap_ctrl[psl_pkg::F_OVR_ANEG];
        force_mdix_o <= strap_ctrl[psl_pkg::F_OVR_MDIX];
        half_duplex_enable_o <= strap_ctrl[psl_pkg::F_OVR_HD];
      end
      else
      begin
        phy_address_o <= {strap[2][0], strap[1], strap[0]};
        autoneg_select_bit1_o <= strap[2][1];
        force_mdix_o <= strap[3][1];
        half_duplex_enable_o <= strap[3][0];
      end
    end
  end
  // Downshift: count consecutive gigabit failures, then step down
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      fail_cnt <= '0;
      gig_failed <= 1'b0;
      speed_o <= psl_pkg::SPD_1000;
      link_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      link_q <= link_up_i;
      if (!spd_en)
      begin
        fail_cnt <= '0;
        gig_failed <= 1'b0;
        speed_o <= psl_pkg::SPD_1000;
      end
      else if (link_up_i)
        fail_cnt <= '0;
      else if (attempt_fail_i)
      begin
        if (speed_o == psl_pkg::SPD_1000)
        begin
          // Enhanced mode skips the count when pairs C/D are dead
          if ((config_four[psl_pkg::F_ENHANCED] && !energy_cd_i) ||
              fail_cnt + 3'h1 >= config_four[psl_pkg::F_THRESH_LO +: 3])
          begin
            speed_o <= psl_pkg::SPD_100;
            gig_failed <= 1'b1;
            fail_cnt <= '0;
          end
          else
            fail_cnt <= fail_cnt + 3'h1;
        end
        else if (speed_o == psl_pkg::SPD_100 && gig_failed)
          speed_o <= psl_pkg::SPD_10;
      end
    end
  end
  // Interrupt events: link change, failed attempt above 10M with speed optimisation, any config_one write
  assign ev[psl_pkg::I_LINK] = link_up_i != link_q;
  assign ev[psl_pkg::I_DOWNSHIFT] = spd_en && attempt_fail_i && speed_o != psl_pkg::SPD_10;
  assign ev[psl_pkg::I_TEST] = wb_wr && idx == psl_pkg::IDX_CONFIG_ONE;
  // Status clears on read; a same-cycle event still sets
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      interrupt_status <= psl_pkg::ZERO16;
      int_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (wb_req && !wb_we_i && idx == psl_pkg::IDX_INT_STATUS)
        interrupt_status <= {13'h0000, ev};
      else
        interrupt_status <= interrupt_status | {13'h0000, ev};
      int_o <= |(interrupt_status & interrupt_mask_control);
    end
  end
  // Media pins: test pattern, mirror with polarity swap, link drop
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      mdi_p_o <= '0;
      mdi_n_o <= '0;
      clk_out_o <= 1'b0;
      test_mode_o <= '0;
      link_drop_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      test_mode_o <= config_one[psl_pkg::F_TEST_LO +: 3];
      link_drop_o <= config_one[psl_pkg::F_LINK_DROP];
      clk_out_o <= (config_one[psl_pkg::F_TEST_LO +: 3] != 3'h0) ? test_clk_i : 1'b0;
      if (config_one[psl_pkg::F_LINK_DROP])
      begin
        mdi_p_o <= '0;
        mdi_n_o <= '0;
      end
      else if (config_one[psl_pkg::F_TEST_LO +: 3] != 3'h0)
      begin
        mdi_p_o <= {4{test_pattern_i}};
        mdi_n_o <= {4{!test_pattern_i}};
      end
      else if (mir_en && speed_o == psl_pkg::SPD_1000)
      begin
        // Full reversal A..D, wires p/n swapped
        mdi_p_o <= {tx_pair_n_i[0], tx_pair_n_i[1], tx_pair_n_i[2], tx_pair_n_i[3]};
        mdi_n_o <= {tx_pair_p_i[0], tx_pair_p_i[1], tx_pair_p_i[2], tx_pair_p_i[3]};
      end
      else if (mir_en)
      begin
        // Only A and B carry data at 10/100, regardless of mdix
        mdi_p_o <= {tx_pair_n_i[0], tx_pair_n_i[1], 2'h0};
        mdi_n_o <= {tx_pair_p_i[0], tx_pair_p_i[1], 2'h0};
      end
      else
      begin
        mdi_p_o <= tx_pair_p_i;
        mdi_n_o <= tx_pair_n_i;
      end
    end
  end
  // Assertions
  a_strap_hold: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    strap_done |=> $stable(strap[0]) && $stable(strap[5])) else $error("strap changed");
  a_link_clear: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    clk_en_i && link_up_i |=> fail_cnt == 3'h0) else $error("fail count not cleared on link");
  a_to_ten: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    clk_en_i && spd_en && attempt_fail_i && !link_up_i && speed_o == psl_pkg::SPD_100
    && gig_failed |=> speed_o == psl_pkg::SPD_10) else $error("no step to 10M");
  a_drop_quiet: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    clk_en_i && config_one[psl_pkg::F_LINK_DROP] |=> mdi_p_o == 4'h0 && link_drop_o)
    else $error("link not dropped");
  a_mirror_gig: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    clk_en_i && mir_en && speed_o == psl_pkg::SPD_1000 && !config_one[psl_pkg::F_LINK_DROP]
    && config_one[psl_pkg::F_TEST_LO +: 3] == 3'h0
    |=> mdi_p_o[3] == $past(tx_pair_n_i[0]) && mdi_n_o[3] == $past(tx_pair_p_i[0]))
    else $error("gigabit mirror wrong");
  a_int_gate: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    clk_en_i && (interrupt_status & interrupt_mask_control) == 16'h0000 |=> !int_o)
    else $error("masked interrupt raised");
  a_sw_keep: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    sw_reset && clk_en_i |=> strap_ctrl == 16'h0000 && $stable(strap[1]))
    else $error("soft reset resampled");
  a_test_mode: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    clk_en_i |=> test_mode_o == $past(config_one[psl_pkg::F_TEST_LO +: 3]))
    else $error("test mode not followed");
endmodule // psl_top
`default_nettype wire

// file: verification/psl_host_model.sv
// Host model: classic Wishbone single cycles into the register block.
// Assumes a slave that acknowledges every request, mapped or not.
`timescale 1ns/10ps
`default_nettype none
module psl_host_model (
  // Clock
  input wire logic clk_i,
  // Wishbone master side
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [9:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o,
  input wire logic [31:0] dat_i,
  input wire logic ack_i
);
  int n_late = 0; // Answers later than the slave's one-cycle answer
  initial
  begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 10'h000;
    sel_o = 4'h0;
    dat_o = 32'h00000000;
  end
  // One request, held until ack is sampled high
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int k;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 4'h3;
    dat_o <= d;
    k = 0;
    // Wait as long as it takes; only the bench watchdog ends a hang
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack_i !== 1'b1);
    // Taken at the first edge, so ack is sampled high at the second
    if (k != 2)
      n_late++;
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // Released lines show no stale value
    adr_o <= ~a;
    dat_o <= ~d;
  endtask
endmodule // psl_host_model
`default_nettype wire

// file: verification/phy_strap_and_link_mode_config_tb.sv
// Self-checking bench: straps, downshift, mirror, test modes, interrupt.
// Assumes psl_host_model as bus master and a fixed random seed.
`timescale 1ns/10ps
`default_nettype none
module phy_strap_and_link_mode_config_tb;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [9:0] lvl [6]; // Strap pins: lines 0,2,4,5, speed opt, mirror
  logic [9:0] ex [6]; // Levels applied at the last hard reset
  logic [9:0] bnd [8]; // Window edges
  logic attempt_fail_i = 1'b0;
  logic link_up_i = 1'b0;
  logic energy_cd_i = 1'b1;
  logic mdix_i = 1'b0;
  logic [3:0] tx_pair_p_i = 4'h0;
  logic [3:0] tx_pair_n_i = 4'h0;
  logic test_pattern_i = 1'b0;
  logic test_clk_i = 1'b0;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [9:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [4:0] phy_address_o;
  logic autoneg_select_bit1_o, force_mdix_o, half_duplex_enable_o;
  logic link_drop_o, clk_out_o, int_o;
  logic [1:0] speed_o;
  logic [2:0] test_mode_o;
  logic [3:0] mdi_p_o, mdi_n_o, m;
  logic [3:0] nib; // Low address nibble of the override write
  int n_errors = 0;
  int total_checks = 0;
  // 200 MHz core clock
  always #2.5 core_clk_i = ~core_clk_i;
  psl_top dut_u (
    .core_clk_i, .resetn_i, .clk_en_i(1'b1),
    .receive_data_line0_lvl_i(lvl[0]), .receive_data_line2_lvl_i(lvl[1]),
    .receive_data_line4_lvl_i(lvl[2]), .receive_data_line5_lvl_i(lvl[3]),
    .speed_opt_lvl_i(lvl[4]), .mirror_lvl_i(lvl[5]),
    .attempt_fail_i, .link_up_i, .energy_cd_i, .mdix_i, .tx_pair_p_i, .tx_pair_n_i,
    .test_pattern_i, .test_clk_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .phy_address_o, .autoneg_select_bit1_o,
    .force_mdix_o, .half_duplex_enable_o, .speed_o, .link_drop_o, .test_mode_o,
    .mdi_p_o, .mdi_n_o, .clk_out_o, .int_o
  );
  psl_host_model host_u (
    .clk_i(core_clk_i), .cyc_o(wb_cyc_i), .stb_o(wb_stb_i), .we_o(wb_we_i),
    .adr_o(wb_adr_i), .sel_o(wb_sel_i), .dat_o(wb_dat_i), .dat_i(wb_dat_o),
    .ack_i(wb_ack_o)
  );
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (n_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Gaps between windows fall to the lower mode
  function automatic logic [1:0] dec(input logic [9:0] v);
    if (v >= psl_pkg::LVL_M4_MIN) return psl_pkg::MODE4;
    if (v >= psl_pkg::LVL_M3_MIN) return psl_pkg::MODE3;
    if (v >= psl_pkg::LVL_M2_MIN) return psl_pkg::MODE2;
    return psl_pkg::MODE1;
  endfunction
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic wr(input logic [7:0] i, input logic [15:0] d);
    host_u.xfer(1'b1, {i, 2'b00}, {16'h0000, d}, q);
  endtask
  task automatic rd(input logic [7:0] i);
    host_u.xfer(1'b0, {i, 2'b00}, 32'h00000000, q);
  endtask
  task automatic hard_reset();
    @(posedge core_clk_i);
    resetn_i <= 1'b0;
    foreach (ex[k]) lvl[k] <= ex[k];
    wt(8);
    chk("speed_o in reset", speed_o, 32'h2);
    resetn_i <= 1'b1;
    wt(8);
  endtask
  task automatic chk_straps();
    logic [1:0] a0, a2, a4, a5;
    a0 = dec(ex[0]);
    a2 = dec(ex[1]);
    a4 = dec(ex[2]);
    a5 = dec(ex[3]);
    chk("phy_address_o", phy_address_o, {a4[0], a2, a0});
    chk("autoneg_select_bit1_o", autoneg_select_bit1_o, a4[1]);
    chk("force_mdix_o", force_mdix_o, a5[1]);
    chk("half_duplex_enable_o", half_duplex_enable_o, a5[0]);
  endtask
  // Failed attempts, one pulse each
  task automatic fails(input int n);
    repeat (n)
    begin
      @(posedge core_clk_i);
      attempt_fail_i <= 1'b1;
      @(posedge core_clk_i);
      attempt_fail_i <= 1'b0;
      wt(3);
    end
  endtask
  // Both crossover settings, pairs reversed and swapped p/n
  task automatic chk_mirror(input bit gig);
    repeat (2)
    begin
      @(posedge core_clk_i);
      tx_pair_p_i <= 4'($urandom);
      tx_pair_n_i <= 4'($urandom);
      mdix_i <= ~mdix_i;
      wt(4);
      m = {tx_pair_n_i[0], tx_pair_n_i[1], tx_pair_n_i[2], tx_pair_n_i[3]};
      chk("mdi_p_o", mdi_p_o, gig ? m : {m[3:2], 2'h0});
      m = {tx_pair_p_i[0], tx_pair_p_i[1], tx_pair_p_i[2], tx_pair_p_i[3]};
      chk("mdi_n_o", mdi_n_o, gig ? m : {m[3:2], 2'h0});
    end
  endtask
  initial
  begin
    foreach (lvl[k]) lvl[k] = 10'h000;
    foreach (ex[k]) ex[k] = 10'h000;
    bnd = '{psl_pkg::LVL_M1_MAX, psl_pkg::LVL_M2_MIN, psl_pkg::LVL_M3_MAX,
      psl_pkg::LVL_M4_MAX, psl_pkg::LVL_M2_MAX, psl_pkg::LVL_M3_MIN,
      psl_pkg::LVL_M4_MIN, 10'h000};
    q = $urandom(16099);
    // Power-up and hard resets, random then window edges
    for (int r = 0; r < 5; r++)
    begin
      for (int k = 0; k < 4; k++)
        ex[k] = (r > 2) ? bnd[(r - 3) * 4 + k] : 10'($urandom % 889);
      hard_reset();
      chk_straps();
      @(posedge core_clk_i);
      foreach (lvl[k]) lvl[k] <= 10'($urandom % 889);
      wt(10);
      chk_straps();
    end
    // Reset values and an unmapped place
    rd(psl_pkg::IDX_CONFIG_FOUR);
    chk("config_four", q, {25'h0, psl_pkg::THRESH_DEFAULT, 4'h0});
    rd(psl_pkg::IDX_CONFIG_ONE);
    chk("config_one", q, 32'h0);
    wr(8'hFF, 16'hFFFF);
    rd(8'hFF);
    chk("unmapped", q, 32'h0);
    // Register override, then software reset restores straps
    m = 4'($urandom);
    nib = 4'($urandom);
    wr(psl_pkg::IDX_STRAP_CTRL, {8'h80, m, nib});
    wt(2);
    chk("phy_address_o", phy_address_o, {m[0], nib});
    chk("autoneg_select_bit1_o", autoneg_select_bit1_o, m[1]);
    chk("force_mdix_o", force_mdix_o, m[2]);
    chk("half_duplex_enable_o", half_duplex_enable_o, m[3]);
    wr(psl_pkg::IDX_STRAP_CTRL, 16'h4000);
    wt(8);
    chk_straps();
    // Default threshold, counter cleared by link
    wr(psl_pkg::IDX_CONFIG_FOUR, 16'h0042);
    fails(3);
    @(posedge core_clk_i);
    link_up_i <= 1'b1;
    wt(2);
    link_up_i <= 1'b0;
    fails(3);
    chk("speed_o", speed_o, 32'h2);
    fails(1);
    chk("speed_o", speed_o, 32'h1);
    fails(1);
    chk("speed_o", speed_o, 32'h0);
    // Random threshold
    hard_reset();
    m = 4'(1 + $urandom % 7);
    wr(psl_pkg::IDX_CONFIG_FOUR, {9'h0, m[2:0], 4'h2});
    fails(int'(m) - 1);
    chk("speed_o", speed_o, 32'h2);
    fails(1);
    chk("speed_o", speed_o, 32'h1);
    // Enhanced mode, energy on C/D then none
    hard_reset();
    wr(psl_pkg::IDX_CONFIG_FOUR, 16'h0046);
    fails(1);
    chk("speed_o", speed_o, 32'h2);
    energy_cd_i <= 1'b0;
    fails(1);
    chk("speed_o", speed_o, 32'h1);
    energy_cd_i <= 1'b1;
    // Speed optimisation from strap only
    ex[4] = psl_pkg::LVL_M3_MIN;
    hard_reset();
    fails(4);
    chk("speed_o", speed_o, 32'h1);
    ex[4] = 10'h000;
    // Mirror by register at gigabit, then at 100M
    hard_reset();
    wr(psl_pkg::IDX_CONFIG_FOUR, 16'h0041);
    chk_mirror(1'b1);
    wr(psl_pkg::IDX_CONFIG_FOUR, 16'h0043);
    fails(4);
    chk_mirror(1'b0);
    // Mirror by strap
    ex[5] = psl_pkg::LVL_M3_MIN;
    hard_reset();
    chk_mirror(1'b1);
    ex[5] = 10'h000;
    hard_reset();
    // Test modes one to four, then normal
    for (int t = 1; t < 6; t++)
    begin
      wr(psl_pkg::IDX_CONFIG_ONE, {3'(t % 5), 13'h0});
      test_pattern_i <= 1'($urandom);
      test_clk_i <= 1'($urandom);
      wt(3);
      chk("test_mode_o", test_mode_o, t % 5);
      if (t < 5) chk("mdi_p_o", mdi_p_o, {4{test_pattern_i}});
      if (t < 5) chk("clk_out_o", clk_out_o, test_clk_i);
    end
    // Link drop
    wr(psl_pkg::IDX_CONFIG_ONE, 16'h0080);
    wt(2);
    chk("link_drop_o", link_drop_o, 32'h1);
    wr(psl_pkg::IDX_CONFIG_ONE, 16'h0000);
    wt(2);
    chk("link_drop_o", link_drop_o, 32'h0);
    // Interrupt masked, raised, cleared by read
    wr(psl_pkg::IDX_INT_MASK, 16'h0000);
    rd(psl_pkg::IDX_INT_STATUS);
    wr(psl_pkg::IDX_CONFIG_ONE, 16'h0000);
    wt(2);
    chk("int_o masked", int_o, 32'h0);
    rd(psl_pkg::IDX_INT_STATUS);
    wr(psl_pkg::IDX_INT_MASK, 16'h0004);
    wr(psl_pkg::IDX_CONFIG_ONE, 16'h0000);
    wt(2);
    chk("int_o", int_o, 32'h1);
    rd(psl_pkg::IDX_INT_STATUS);
    chk("int_status", q[2], 32'h1);
    wt(2);
    chk("int_o cleared", int_o, 32'h0);
    wr(psl_pkg::IDX_INT_STATUS, 16'h0004);
    rd(psl_pkg::IDX_INT_STATUS);
    chk("int_status", q[2], 32'h0);
    chk("late bus answers", host_u.n_late, 32'h0);
    complete_run();
  end
  // Watchdog
  initial
  begin
    #100000;
    n_errors++;
    complete_run();
  end
endmodule // phy_strap_and_link_mode_config_tb
`default_nettype wire
